/* File: core/cfd_datapath.sv */
`timescale 1ns/100ps
module cfd_datapath
  import cfd_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] io_port_addr,
  output logic [7:0] instr_byte,
  output logic busy
);

  cfd_state_t state_q, state_d;
  logic ce_q, ce_d;
  logic [7:0] a_q, a_d, a_alt_q, a_alt_d;
  cfd_flags_t f_q, f_d, f_alt_q, f_alt_d;
  logic [7:0] regs_q [0:NUM_GP-1];
  logic [7:0] regs_d [0:NUM_GP-1];
  logic [7:0] alt_q [0:NUM_GP-1];
  logic [7:0] alt_d [0:NUM_GP-1];
  logic [7:0] ivec_q, ivec_d, rfsh_q, rfsh_d;
  logic [7:0] ir_q, ir_d, buf_q, buf_d, opnd_q, opnd_d, port_q, port_d;
  logic [15:0] stack_q, stack_d;
  logic taken_q, taken_d;
  logic [31:0] prdata_q, prdata_d;

  logic [2:0] sel;
  cfd_op_t op;
  logic [15:0] count_pair, second_pointer_pair, memory_pointer_pair;
  logic cmd_wr;
  logic [7:0] src, res, corr;
  logic [8:0] s9;
  logic [4:0] h5;
  logic [15:0] p16;
  logic cin, cy, wr_en;
  cfd_flags_t fl;

  // parity, sign and zero from a result; shared by the parity-reporting ops
  function automatic cfd_flags_t szp(input cfd_flags_t f, input logic [7:0] v);
    cfd_flags_t t;
    t = f;
    t.s = v[7];
    t.z = (v == 8'h00);
    t.pv = ~^v;
    return t;
  endfunction : szp

  // only four flags can steer a branch
  function automatic logic cond_true(input cfd_flags_t f, input logic [2:0] cc);
    logic t;
    t = 1'b0;
    unique case (cc)
      3'h0: t = ~f.z;
      3'h1: t = f.z;
      3'h2: t = ~f.c;
      3'h3: t = f.c;
      3'h4: t = ~f.pv;
      3'h5: t = f.pv;
      3'h6: t = ~f.s;
      3'h7: t = f.s;
    endcase
    return t;
  endfunction : cond_true

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_CMD) || (a == OFS_ACC) || (a == OFS_CNT_PAIR) ||
      (a == OFS_PTR2_PAIR) || (a == OFS_MEM_PAIR) || (a == OFS_STACK) ||
      (a == OFS_STATUS) || (a == OFS_MISC);
  endfunction : addr_mapped

  // pairs are plain concatenations, first-named register as high byte
  assign count_pair = {regs_q[IDX_B], regs_q[IDX_C]};
  assign second_pointer_pair = {regs_q[IDX_D], regs_q[IDX_E]};
  assign memory_pointer_pair = {regs_q[IDX_H], regs_q[IDX_L]};

  // the decoder reads only the instruction register, never the bus buffer
  assign sel = ir_q[2:0];
  assign op = cfd_op_t'(ir_q[7:3]);

  // a command is accepted only while idle; later ones are dropped
  assign cmd_wr = psel && penable && pwrite && pstrb[0] && (paddr == OFS_CMD);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign prdata = prdata_q;
  assign io_port_addr = port_q;
  assign instr_byte = ir_q;
  assign busy = (state_q != st_idle);

  // next state of sequencer, divider and whole register array
  always_comb
  begin
    state_d = state_q;
    ce_d = ~ce_q;
    a_d = a_q;
    a_alt_d = a_alt_q;
    f_alt_d = f_alt_q;
    regs_d = regs_q;
    alt_d = alt_q;
    ivec_d = ivec_q;
    rfsh_d = rfsh_q;
    ir_d = ir_q;
    buf_d = buf_q;
    opnd_d = opnd_q;
    port_d = port_q;
    stack_d = stack_q;
    taken_d = taken_q;
    fl = f_q;
    res = 8'h00;
    corr = 8'h00;
    s9 = 9'h000;
    h5 = 5'h00;
    p16 = 16'h0000;
    cin = 1'b0;
    cy = f_q.c;
    wr_en = 1'b0;
    if (sel == SEL_A)
      src = a_q;
    else if (sel == SEL_IMM)
      src = opnd_q;
    else
      src = regs_q[sel];
    unique case (state_q)
      st_idle:
      begin
        if (cmd_wr)
        begin
          buf_d = pwdata[CMD_INSTR_LSB +: 8];
          if (pstrb[1])
            opnd_d = pwdata[CMD_OPND_LSB +: 8];
          state_d = st_fetch;
        end
      end
      st_fetch:
      begin
        if (ce_q)
        begin
          ir_d = buf_q;
          rfsh_d = rfsh_q + 8'h01;
          state_d = st_exec;
        end
      end
      st_exec:
      begin
        if (ce_q)
        begin
          state_d = st_idle;
          unique case (op)
            nop_op:
            begin
            end
            load_op:
            begin
              res = opnd_q;
              wr_en = 1'b1;
            end
            add_op, adc_op:
            begin
              cin = f_q.c && (op == adc_op);
              s9 = {1'b0, a_q} + {1'b0, src} + {8'h00, cin};
              h5 = {1'b0, a_q[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
              res = s9[7:0];
              a_d = res;
              fl = szp(f_q, res);
              fl.c = s9[8];
              fl.h = h5[4];
              fl.pv = (a_q[7] == src[7]) && (res[7] != a_q[7]);
              fl.n = 1'b0;
            end
            sub_op, sbc_op:
            begin
              cin = f_q.c && (op == sbc_op);
              s9 = {1'b0, a_q} - {1'b0, src} - {8'h00, cin};
              h5 = {1'b0, a_q[3:0]} - {1'b0, src[3:0]} - {4'h0, cin};
              res = s9[7:0];
              a_d = res;
              fl = szp(f_q, res);
              fl.c = s9[8];
              fl.h = h5[4];
              fl.pv = (a_q[7] != src[7]) && (res[7] != a_q[7]);
              fl.n = 1'b1;
            end
            and_op, or_op, xor_op:
            begin
              if (op == and_op)
                res = a_q & src;
              else if (op == or_op)
                res = a_q | src;
              else
                res = a_q ^ src;
              a_d = res;
              fl = szp(f_q, res);
              fl.h = (op == and_op);
              fl.c = 1'b0;
              fl.n = 1'b0;
            end
            jump_cond_op:
            begin
              taken_d = cond_true(f_q, sel);
            end
            inc_op, dec_op:
            begin
              // carry is left alone so multi-byte loops keep it
              res = (op == inc_op) ? src + 8'h01 : src - 8'h01;
              wr_en = 1'b1;
              fl = szp(f_q, res);
              fl.h = (op == inc_op) ? (src[3:0] == 4'hf) : (src[3:0] == 4'h0);
              fl.pv = (op == inc_op) ? (src == 8'h7f) : (src == 8'h80);
              fl.n = (op == dec_op);
            end
            rot_acc_op:
            begin
              // short form: sign, zero and parity stay as they were
              a_d = {a_q[6:0], a_q[7]};
              fl.c = a_q[7];
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            rot_reg_op, shift_right_op:
            begin
              res = (op == rot_reg_op) ? {src[6:0], src[7]} : {1'b0, src[7:1]};
              wr_en = 1'b1;
              fl = szp(f_q, res);
              fl.c = (op == rot_reg_op) ? src[7] : src[0];
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            decimal_adjust_op:
            begin
              if (f_q.h || (a_q[3:0] > 4'h9))
                corr[3:0] = 4'h6;
              if (f_q.c || (a_q > 8'h99))
              begin
                corr[7:4] = 4'h6;
                cy = 1'b1;
              end
              res = f_q.n ? a_q - corr : a_q + corr;
              a_d = res;
              fl = szp(f_q, res);
              fl.c = cy;
              fl.h = f_q.n ? (f_q.h && (a_q[3:0] < 4'h6)) : (a_q[3:0] > 4'h9);
            end
            compl_acc_op:
            begin
              a_d = ~a_q;
              fl.h = 1'b1;
              fl.n = 1'b1;
            end
            negate_op:
            begin
              res = 8'h00 - a_q;
              a_d = res;
              fl = szp(f_q, res);
              fl.c = (a_q != 8'h00);
              fl.pv = (a_q == 8'h80);
              fl.h = (a_q[3:0] != 4'h0);
              fl.n = 1'b1;
            end
            force_carry_op:
            begin
              fl.c = 1'b1;
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            invert_carry_op:
            begin
              // half carry has no meaning here and is left as it was
              fl.c = ~f_q.c;
              fl.n = 1'b0;
            end
            exchange_op:
            begin
              if (!sel[0])
              begin
                a_d = a_alt_q;
                a_alt_d = a_q;
                fl = f_alt_q;
                f_alt_d = f_q;
              end
              else
              begin
                regs_d = alt_q;
                alt_d = regs_q;
              end
            end
            count_down_branch_op:
            begin
              res = regs_q[IDX_B] - 8'h01;
              regs_d[IDX_B] = res;
              taken_d = (res != 8'h00);
            end
            push_acc_flags_op:
            begin
              stack_d = {a_q, f_q};
            end
            port_in_op:
            begin
              // operand stands in for the byte returned by the port
              port_d = regs_q[IDX_C];
              res = opnd_q;
              wr_en = 1'b1;
              fl = szp(f_q, res);
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            load_a_vec_op:
            begin
              res = sel[0] ? rfsh_q : ivec_q;
              a_d = res;
              fl = szp(f_q, res);
              fl.pv = 1'b0;
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            store_a_vec_op:
            begin
              if (sel[0])
                rfsh_d = a_q;
              else
                ivec_d = a_q;
            end
            bit_test_op:
            begin
              // sign and parity carry no meaning afterwards and are kept
              fl.z = ~src[opnd_q[2:0]];
              fl.h = 1'b1;
              fl.n = 1'b0;
            end
            blk_move_op:
            begin
              p16 = memory_pointer_pair + 16'h0001;
              {regs_d[IDX_H], regs_d[IDX_L]} = p16;
              p16 = second_pointer_pair + 16'h0001;
              {regs_d[IDX_D], regs_d[IDX_E]} = p16;
              p16 = count_pair - 16'h0001;
              {regs_d[IDX_B], regs_d[IDX_C]} = p16;
              fl.pv = (p16 != 16'h0000);
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            blk_move_rep_op:
            begin
              // the whole run is collapsed into one step
              p16 = memory_pointer_pair + count_pair;
              {regs_d[IDX_H], regs_d[IDX_L]} = p16;
              p16 = second_pointer_pair + count_pair;
              {regs_d[IDX_D], regs_d[IDX_E]} = p16;
              {regs_d[IDX_B], regs_d[IDX_C]} = RST_WORD;
              fl.pv = 1'b0;
              fl.h = 1'b0;
              fl.n = 1'b0;
            end
            blk_search_op:
            begin
              s9 = {1'b0, a_q} - {1'b0, opnd_q};
              h5 = {1'b0, a_q[3:0]} - {1'b0, opnd_q[3:0]};
              res = s9[7:0];
              fl.s = res[7];
              fl.z = (res == 8'h00);
              fl.h = h5[4];
              fl.n = 1'b1;
              p16 = memory_pointer_pair + 16'h0001;
              {regs_d[IDX_H], regs_d[IDX_L]} = p16;
              p16 = count_pair - 16'h0001;
              {regs_d[IDX_B], regs_d[IDX_C]} = p16;
              fl.pv = (p16 != 16'h0000);
            end
            blk_in_op:
            begin
              port_d = regs_q[IDX_C];
              res = regs_q[IDX_B] - 8'h01;
              regs_d[IDX_B] = res;
              p16 = memory_pointer_pair + 16'h0001;
              {regs_d[IDX_H], regs_d[IDX_L]} = p16;
              fl.z = (res == 8'h00);
              fl.n = 1'b1;
            end
            blk_in_rep_op:
            begin
              port_d = regs_q[IDX_C];
              p16 = memory_pointer_pair + {8'h00, regs_q[IDX_B]};
              {regs_d[IDX_H], regs_d[IDX_L]} = p16;
              regs_d[IDX_B] = RST_BYTE;
              fl.z = 1'b1;
              fl.n = 1'b1;
            end
          endcase
        end
      end
      default: state_d = st_idle;
    endcase
    // destination write of the single-register ops
    if (wr_en)
    begin
      if (sel == SEL_A)
        a_d = res;
      else if (sel != SEL_IMM)
        regs_d[sel] = res;
    end
    fl.b5 = 1'b0;
    fl.b3 = 1'b0;
    f_d = fl;
  end

  // the flag byte is never a bus write target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
      ce_q <= 1'b0;
      a_q <= RST_BYTE;
      a_alt_q <= RST_BYTE;
      f_q <= RST_BYTE;
      f_alt_q <= RST_BYTE;
      regs_q <= '{default: RST_BYTE};
      alt_q <= '{default: RST_BYTE};
      ivec_q <= RST_BYTE;
      rfsh_q <= RST_BYTE;
      ir_q <= RST_BYTE;
      buf_q <= RST_BYTE;
      opnd_q <= RST_BYTE;
      port_q <= RST_BYTE;
      stack_q <= RST_WORD;
      taken_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ce_q <= ce_d;
      a_q <= a_d;
      a_alt_q <= a_alt_d;
      f_q <= f_d;
      f_alt_q <= f_alt_d;
      regs_q <= regs_d;
      alt_q <= alt_d;
      ivec_q <= ivec_d;
      rfsh_q <= rfsh_d;
      ir_q <= ir_d;
      buf_q <= buf_d;
      opnd_q <= opnd_d;
      port_q <= port_d;
      stack_q <= stack_d;
      taken_q <= taken_d;
    end
  end

  // read data is taken in the setup cycle so the access phase never waits
  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
    begin
      prdata_d = RST_RDATA;
      unique case (paddr)
        OFS_CMD: prdata_d = {16'h0000, opnd_q, buf_q};
        OFS_ACC: prdata_d = {24'h000000, a_q};
        OFS_CNT_PAIR: prdata_d = {16'h0000, count_pair};
        OFS_PTR2_PAIR: prdata_d = {16'h0000, second_pointer_pair};
        OFS_MEM_PAIR: prdata_d = {16'h0000, memory_pointer_pair};
        OFS_STACK: prdata_d = {16'h0000, stack_q};
        OFS_STATUS: prdata_d = {30'h0, taken_q, busy};
        OFS_MISC: prdata_d = {port_q, rfsh_q, ivec_q, ir_q};
        default: prdata_d = RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= RST_RDATA;
    else
      prdata_q <= prdata_d;
  end

endmodule : cfd_datapath

/* File: core/cfd_pkg.sv */
package cfd_pkg;

  // register offsets on the apb bus (byte addresses, one word each)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_CNT_PAIR = 8'h08;
  localparam logic [7:0] OFS_PTR2_PAIR = 8'h0c;
  localparam logic [7:0] OFS_MEM_PAIR = 8'h10;
  localparam logic [7:0] OFS_STACK = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MISC = 8'h1c;

  // field positions
  localparam int unsigned CMD_INSTR_LSB = 0;
  localparam int unsigned CMD_OPND_LSB = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_TAKEN_BIT = 1;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // internal rate is the bus clock divided by this
  localparam int unsigned CLK_DIV = 2;

  // byte register selectors held in the low three instruction bits
  localparam int unsigned NUM_GP = 6;
  localparam logic [2:0] IDX_B = 3'h0;
  localparam logic [2:0] IDX_C = 3'h1;
  localparam logic [2:0] IDX_D = 3'h2;
  localparam logic [2:0] IDX_E = 3'h3;
  localparam logic [2:0] IDX_H = 3'h4;
  localparam logic [2:0] IDX_L = 3'h5;
  localparam logic [2:0] SEL_IMM = 3'h6;
  localparam logic [2:0] SEL_A = 3'h7;

  // flag byte layout, bits 5 and 3 carry no status and stay zero
  typedef struct packed {
    logic s;
    logic z;
    logic b5;
    logic h;
    logic b3;
    logic pv;
    logic n;
    logic c;
  } cfd_flags_t;

  // operation held in the upper five instruction bits
  typedef enum logic [4:0] {
    nop_op = 5'h00, load_op = 5'h01, add_op = 5'h02, adc_op = 5'h03,
    sub_op = 5'h04, sbc_op = 5'h05, and_op = 5'h06, or_op = 5'h07,
    xor_op = 5'h08, jump_cond_op = 5'h09, inc_op = 5'h0a, dec_op = 5'h0b,
    rot_acc_op = 5'h0c, rot_reg_op = 5'h0d, shift_right_op = 5'h0e,
    decimal_adjust_op = 5'h0f, compl_acc_op = 5'h10, negate_op = 5'h11,
    force_carry_op = 5'h12, invert_carry_op = 5'h13, exchange_op = 5'h14,
    count_down_branch_op = 5'h15, push_acc_flags_op = 5'h16, port_in_op = 5'h17,
    load_a_vec_op = 5'h18, store_a_vec_op = 5'h19, bit_test_op = 5'h1a,
    blk_move_op = 5'h1b, blk_move_rep_op = 5'h1c, blk_search_op = 5'h1d,
    blk_in_op = 5'h1e, blk_in_rep_op = 5'h1f
  } cfd_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_fetch = 2'b01,
    st_exec = 2'b10
  } cfd_state_t;

endpackage : cfd_pkg

/* File: verif/cfd_datapath_monitor.sv */
`timescale 1ns/100ps
// watches the bus and control outputs of the datapath only
module cfd_datapath_monitor
  import cfd_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [7:0] io_port_addr,
  input logic [7:0] instr_byte,
  input logic busy
);
  logic cmd_wr;
  logic mapped;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  // a command counts only when idle; writes while busy are dropped
  assign cmd_wr = psel && penable && pwrite && paddr == OFS_CMD && !busy;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= OFS_MISC;
  // remember the accepted byte, the fetch shows it a few edges later
  always_comb
  begin
    cmd_d = cmd_q;
    if (cmd_wr && pstrb[0])
    begin
      cmd_d = pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= 8'h00;
    end
    else
    begin
      cmd_q <= cmd_d;
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_cmd_starts: assert property (cmd_wr && pstrb[0] |=> busy)
    else $error("busy did not rise");
  chk_lane_gate: assert property (cmd_wr && !pstrb[0] |=> !busy)
    else $error("unstrobed command ran");
  chk_busy_span: assert property ($rose(busy) |-> busy[*3] ##[1:2] !busy)
    else $error("command length wrong");
  chk_fetch_loads: assert property (cmd_wr && pstrb[0] |-> ##[2:3] instr_byte == cmd_q)
    else $error("instruction not fetched");
  chk_instr_hold: assert property (!busy |=> $stable(instr_byte))
    else $error("instruction moved while idle");
  chk_port_hold: assert property (!busy |=> $stable(io_port_addr))
    else $error("port moved while idle");
  chk_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped");
  chk_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped");
  chk_err_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == RST_RDATA)
    else $error("unmapped read not zero");
  // the bench never waits a fixed time, so a stalled slave would only show as a hang
  chk_no_wait: assert property (psel && penable |-> pready)
    else $error("access phase stalled");
endmodule : cfd_datapath_monitor
bind cfd_datapath cfd_datapath_monitor u_cfd_datapath_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_port_addr(io_port_addr), .instr_byte(instr_byte), .busy(busy));

/* File: verif/cfd_datapath_tb.sv */
`timescale 1ns/100ps
module cfd_datapath_tb
  import cfd_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] io_port_addr;
  logic [7:0] instr_byte;
  logic busy;
  logic [31:0] rd;
  logic err;
  logic [7:0] taken;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  cfd_datapath u_cfd_datapath (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_port_addr(io_port_addr),
    .instr_byte(instr_byte), .busy(busy));

  // 10 mhz bus clock
  always #50 pclk = ~pclk;

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
    begin
      $display("TEST PASSED");
    end
    else
    begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // cut a hang short; normal runs need well under a thousand cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // issue a command and poll until the datapath is idle again
  task automatic exec(input cfd_op_t op, input logic [2:0] sel, input logic [7:0] opnd);
    apb(1'b1, OFS_CMD, {16'h0000, opnd, op, sel}, 4'hf);
    do
    begin
      apb(1'b0, OFS_STATUS, 32'h0, 4'hf);
    end
    while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : exec

  // flags are only visible through a push; m hides bits left open
  task automatic push_chk(input logic [7:0] a, input logic [7:0] f, input logic [7:0] m);
    exec(push_acc_flags_op, 3'h0, 8'h00);
    apb(1'b0, OFS_STACK, 32'h0, 4'hf);
    chk({rd[15:8], rd[7:0] & m}, {a, f});
  endtask : push_chk

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    taken = 8'h66;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_ACC, 32'h0, 4'hf);
    chk(rd[15:0], RST_WORD);
    // a load writes the register named by the selector, so sel 7 targets the accumulator
    exec(load_op, SEL_A, 8'h7f);
    exec(add_op, SEL_IMM, 8'h01);
    push_chk(8'h80, 8'h94, 8'hff);
    exec(sub_op, SEL_IMM, 8'h81);
    push_chk(8'hff, 8'h93, 8'hff);
    exec(and_op, SEL_IMM, 8'h0f);
    push_chk(8'h0f, 8'h14, 8'hff);
    exec(xor_op, SEL_IMM, 8'h0f);
    push_chk(8'h00, 8'h44, 8'hff);
    exec(force_carry_op, 3'h0, 8'h00);
    push_chk(8'h00, 8'h45, 8'hff);
    exec(invert_carry_op, 3'h0, 8'h00);
    push_chk(8'h00, 8'h44, 8'hef);
    // every branch condition against sign 0, zero 1, parity 1, carry 0
    for (int i = 0; i < 8; i++)
    begin
      exec(jump_cond_op, 3'(i), 8'h00);
      apb(1'b0, OFS_STATUS, 32'h0, 4'hf);
      chk({15'h0, rd[STAT_TAKEN_BIT]}, {15'h0, taken[i]});
    end
    exec(count_down_branch_op, 3'h0, 8'h00);
    chk({15'h0, rd[STAT_TAKEN_BIT]}, 16'h0001);
    apb(1'b0, OFS_CNT_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'hff00);
    exec(exchange_op, 3'h1, 8'h00);
    apb(1'b0, OFS_CNT_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'h0000);
    exec(exchange_op, 3'h1, 8'h00);
    apb(1'b0, OFS_CNT_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'hff00);
    exec(exchange_op, 3'h0, 8'h00);
    push_chk(8'h00, 8'h00, 8'hff);
    exec(exchange_op, 3'h0, 8'h00);
    exec(blk_move_rep_op, 3'h0, 8'h00);
    apb(1'b0, OFS_CNT_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'h0000);
    push_chk(8'h00, 8'h00, 8'h16);
    // the last push left accumulator 00 and flags 40; a bus write must not disturb them
    apb(1'b1, OFS_STACK, 32'hffff_ffff, 4'hf);
    apb(1'b0, OFS_STACK, 32'h0, 4'hf);
    chk(rd[15:0], 16'h0040);
    // a command without lane 0 must not run
    apb(1'b1, OFS_CMD, {16'h0000, 8'h00, inc_op, SEL_A}, 4'he);
    apb(1'b0, OFS_ACC, 32'h0, 4'hf);
    chk(rd[15:0], 16'h0000);
    exec(inc_op, SEL_A, 8'h00);
    apb(1'b0, OFS_ACC, 32'h0, 4'hf);
    chk(rd[15:0], 16'h0001);
    chk({8'h00, instr_byte}, {8'h00, inc_op, SEL_A});
    // port input: low count register addresses the port, operand stands for the data
    exec(load_op, IDX_C, 8'h5a);
    exec(port_in_op, SEL_A, 8'h00);
    push_chk(8'h00, 8'h44, 8'hff);
    chk({8'h00, io_port_addr}, 16'h005a);
    exec(load_op, SEL_A, 8'h80);
    exec(negate_op, 3'h0, 8'h00);
    push_chk(8'h80, 8'h87, 8'hff);
    exec(compl_acc_op, 3'h0, 8'h00);
    push_chk(8'h7f, 8'h97, 8'hff);
    exec(dec_op, SEL_A, 8'h00);
    push_chk(8'h7e, 8'h03, 8'hff);
    exec(rot_acc_op, 3'h0, 8'h00);
    push_chk(8'hfc, 8'h00, 8'hff);
    exec(rot_reg_op, SEL_A, 8'h00);
    push_chk(8'hf9, 8'h85, 8'hff);
    // packed decimal 19 + 28 needs the low-digit correction driven by half carry
    exec(load_op, SEL_A, 8'h19);
    exec(add_op, SEL_IMM, 8'h28);
    exec(decimal_adjust_op, 3'h0, 8'h00);
    push_chk(8'h47, 8'h04, 8'hff);
    // repeated block input with a count of three; only zero, subtract and carry are defined
    exec(load_op, IDX_B, 8'h03);
    exec(blk_in_rep_op, 3'h0, 8'h00);
    push_chk(8'h47, 8'h42, 8'h43);
    apb(1'b0, OFS_MEM_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'hff03);
    apb(1'b0, OFS_CNT_PAIR, 32'h0, 4'hf);
    chk(rd[15:0], 16'h005a);
    exec(blk_search_op, 3'h0, 8'h48);
    push_chk(8'h47, 8'h86, 8'hef);
    exec(bit_test_op, SEL_A, 8'h03);
    push_chk(8'h47, 8'h50, 8'h53);
    exec(store_a_vec_op, 3'h0, 8'h00);
    exec(load_op, SEL_A, 8'h00);
    exec(load_a_vec_op, 3'h0, 8'h00);
    push_chk(8'h47, 8'h00, 8'hff);
    apb(1'b0, 8'h20, 32'h0, 4'hf);
    chk({err, rd[14:0]}, 16'h8000);
    stop_test();
  end
endmodule : cfd_datapath_tb
